//--- rtl/gpio_cfg.svh
// Offsets, field positions, codes and reset values of the pin group controller.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
// ==========================================
// Register indices (byte address is four times the index)
`define IDX_DIR         6'h00
`define IDX_DIR_SET     6'h01
`define IDX_DIR_CLR     6'h02
`define IDX_DIR_TGL     6'h03
`define IDX_OUT         6'h04
`define IDX_OUT_SET     6'h05
`define IDX_OUT_CLR     6'h06
`define IDX_OUT_TGL     6'h07
`define IDX_IN          6'h08
`define IDX_FLAGS       6'h09
`define IDX_SETUP_BASE  6'h10
`define IDX_ALIAS_DIR   6'h20
`define IDX_ALIAS_OUT   6'h21
`define IDX_ALIAS_IN    6'h22
`define IDX_ALIAS_FLAGS 6'h23
// ==========================================
// Setup register fields
`define SETUP_FLIP_BIT  7
`define SETUP_PULL_BIT  3
`define SETUP_SENSE_LSB 0
// ==========================================
// Sense select codes
`define SENSE_NO_IRQ    3'h0
`define SENSE_ANY       3'h1
`define SENSE_RISE      3'h2
`define SENSE_FALL      3'h3
`define SENSE_OFF       3'h4
`define SENSE_LEVEL     3'h5
// ==========================================
// Reset values and timing
`define RESET_BYTE      8'h00
`define DEAD_CYCLES     2'h3
`endif

//--- rtl/gpio_pin_group.sv
// Eight-pin GPIO group controller with an AHB-Lite register slave.
`include "gpio_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_group
    import gpio_pkg::*;
#(
    parameter logic [7:0] ASYNC_PINS = 8'h04 // Pins exempt from dead time that may wake in any interrupt-enabled sense mode.
) (
    input  wire logic        sys_clk,   // 100 MHz clock
    input  wire logic        reset,     // Asynchronous reset, active high
    input  wire logic        ce,        // Clock enable, freezes all state when low
    input  wire logic        hsel,      // AHB slave select
    input  wire logic [31:0] haddr,     // AHB address
    input  wire logic [1:0]  htrans,    // AHB transfer type
    input  wire logic        hwrite,    // AHB write
    input  wire logic [2:0]  hsize,     // AHB size, word only
    input  wire logic [31:0] hwdata,    // AHB write data
    input  wire logic        hready,    // AHB bus ready
    output var  logic        hreadyout, // AHB slave ready
    output var  logic [31:0] hrdata,    // AHB read data
    output var  logic        hresp,     // AHB response, always OKAY
    input  wire logic [7:0]  pad_in,    // Pad input levels
    output var  logic [7:0]  pad_out,   // Pad output levels
    output var  logic [7:0]  pad_oe,    // Pad output enables
    output var  logic [7:0]  pad_pull,  // Pad pull-up enables
    output var  logic [7:0]  pin_value, // Sensed pin levels for peripherals and events
    output var  logic        irq,       // Pin group interrupt request
    output var  logic        wake       // Wake request to the sleep controller
);

    port_state_type st_reg;
    port_state_type st_next;

    logic [7:0]  hit;
    logic [7:0]  irq_en;
    logic [7:0]  wake_term;
    logic [7:0]  off_mask;
    logic [7:0]  flip_vec;
    logic [7:0]  sensed;
    logic [7:0]  lvl_n;
    logic [15:0] dead_n;
    logic [5:0]  wr_idx;
    logic [7:0]  wd;
    logic        accept;

    // Fold the alias window onto the regular registers so both paths share one decoder.
    function automatic logic [5:0] map_index(input logic [5:0] idx);
        if (idx == `IDX_ALIAS_DIR) begin
            map_index = `IDX_DIR;
        end else if (idx == `IDX_ALIAS_OUT) begin
            map_index = `IDX_OUT;
        end else if (idx == `IDX_ALIAS_IN) begin
            map_index = `IDX_IN;
        end else if (idx == `IDX_ALIAS_FLAGS) begin
            map_index = `IDX_FLAGS;
        end else begin
            map_index = idx;
        end
    endfunction : map_index

    assign wr_idx = map_index(st_reg.dp_idx);
    assign wd     = hwdata[7:0];
    assign accept = hsel & htrans[1] & hready;

    // ==========================================
    // Per-pin sensing
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            logic [2:0] sel;
            logic       rise;
            logic       fall;
            logic       cond;
            logic       blocked;
            assign sel         = st_reg.setup[i*8+`SETUP_SENSE_LSB +: 3];
            assign flip_vec[i] = st_reg.setup[i*8+`SETUP_FLIP_BIT];
            assign off_mask[i] = (sel == `SENSE_OFF);
            // A polarity change flips the sensed level, so it reads as an edge.
            assign sensed[i]   = st_reg.lvl[i] ^ flip_vec[i];
            assign rise        = sensed[i] & ~st_reg.prev[i];
            assign fall        = ~sensed[i] & st_reg.prev[i];
            assign irq_en[i]   = (sel == `SENSE_ANY) | (sel == `SENSE_RISE) |
                                 (sel == `SENSE_FALL) | (sel == `SENSE_LEVEL);
            // A sense change re-decodes the pending edge at once, so it may be dropped.
            always_comb begin
                case (sel)
                    `SENSE_ANY:   cond = rise | fall;
                    `SENSE_RISE:  cond = rise;
                    `SENSE_FALL:  cond = fall;
                    `SENSE_LEVEL: cond = ~sensed[i];
                    default:      cond = 1'b0;
                endcase
            end
            assign blocked = (st_reg.dead[i*2 +: 2] != 2'h0) & ~ASYNC_PINS[i];
            assign hit[i]  = cond & ~blocked;
            assign dead_n[i*2 +: 2] = hit[i] ? `DEAD_CYCLES :
                (st_reg.dead[i*2 +: 2] != 2'h0) ? st_reg.dead[i*2 +: 2] - 2'h1 : 2'h0;
            // A level counts once the second and third stages agree.
            assign lvl_n[i] = (st_reg.s2[i] == st_reg.s3[i]) ? st_reg.s3[i] : st_reg.lvl[i];
            assign wake_term[i] = st_reg.flags[i] & irq_en[i] &
                (ASYNC_PINS[i] | (sel == `SENSE_ANY) | (sel == `SENSE_LEVEL));
        end
    endgenerate

    // ==========================================
    // Next state
    always_comb begin
        st_next = st_reg;
        // Receiver off stops the synchroniser, so a half-seen edge survives until re-enable.
        st_next.s1   = (pad_in & ~off_mask) | (st_reg.s1 & off_mask);
        st_next.s2   = (st_reg.s1 & ~off_mask) | (st_reg.s2 & off_mask);
        st_next.s3   = (st_reg.s2 & ~off_mask) | (st_reg.s3 & off_mask);
        st_next.lvl  = (lvl_n & ~off_mask) | (st_reg.lvl & off_mask);
        st_next.prev = (sensed & ~off_mask) | (st_reg.prev & off_mask);
        st_next.dead = dead_n;
        if (st_reg.dp_wr) begin
            if (wr_idx == `IDX_DIR) begin
                st_next.dir = wd;
            end else if (wr_idx == `IDX_DIR_SET) begin
                st_next.dir = st_reg.dir | wd;
            end else if (wr_idx == `IDX_DIR_CLR) begin
                st_next.dir = st_reg.dir & ~wd;
            end else if (wr_idx == `IDX_DIR_TGL) begin
                st_next.dir = st_reg.dir ^ wd;
            end else if (wr_idx == `IDX_OUT) begin
                st_next.out = wd;
            end else if (wr_idx == `IDX_OUT_SET) begin
                st_next.out = st_reg.out | wd;
            end else if (wr_idx == `IDX_OUT_CLR) begin
                st_next.out = st_reg.out & ~wd;
            end else if (wr_idx == `IDX_OUT_TGL || wr_idx == `IDX_IN) begin
                st_next.out = st_reg.out ^ wd;
            end else if (wr_idx == `IDX_FLAGS) begin
                st_next.flags = st_reg.flags & ~wd;
            end else if (wr_idx[5:3] == 3'h2) begin
                st_next.setup[wr_idx[2:0]*8 +: 8] = wd;
            end
        end
        // A new event wins over a clear written in the same cycle.
        st_next.flags   = st_next.flags | hit;
        st_next.irq     = |(st_next.flags & irq_en);
        st_next.wake    = |wake_term;
        st_next.pad_oe  = st_next.dir;
        st_next.pad_out = st_next.out ^ flip_vec;
        st_next.pull    = flip_vec & 8'h00;
        for (int k = 0; k < 8; k++) begin
            st_next.pull[k] = st_reg.setup[k*8+`SETUP_PULL_BIT];
        end
        st_next.pin_val = sensed;
        // Bus: writes are zero-wait, reads take one wait state to show fresh state.
        st_next.dp_wr = accept & hwrite;
        st_next.dp_rd = accept & ~hwrite;
        if (accept) begin
            st_next.dp_idx = haddr[7:2];
        end
        st_next.resp  = 1'b0;
        st_next.ready = 1'b1;
        if (accept & ~hwrite) begin
            st_next.ready = 1'b0;
        end
        if (st_reg.dp_rd & ~st_reg.ready) begin
            st_next.rdata = 32'h0000_0000;
            if (wr_idx <= `IDX_DIR_TGL) begin
                st_next.rdata[7:0] = st_reg.dir;
            end else if (wr_idx <= `IDX_OUT_TGL) begin
                st_next.rdata[7:0] = st_reg.out;
            end else if (wr_idx == `IDX_IN) begin
                st_next.rdata[7:0] = sensed;
            end else if (wr_idx == `IDX_FLAGS) begin
                st_next.rdata[7:0] = st_reg.flags;
            end else if (wr_idx[5:3] == 3'h2) begin
                st_next.rdata[7:0] = st_reg.setup[wr_idx[2:0]*8 +: 8];
            end
        end
    end

    // ==========================================
    // State register
    // No debug input exists, so a halted core sees the port run on unchanged.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_reg       <= '0;
            st_reg.ready <= 1'b1;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = st_reg.ready;
    assign hrdata    = st_reg.rdata;
    assign hresp     = st_reg.resp;
    assign pad_out   = st_reg.pad_out;
    assign pad_oe    = st_reg.pad_oe;
    assign pad_pull  = st_reg.pull;
    assign pin_value = st_reg.pin_val;
    assign irq       = st_reg.irq;
    assign wake      = st_reg.wake;

    // ==========================================
    // Checks
    chk_dir_set_bits: assert property (@(posedge sys_clk) disable iff (reset)
        ce && st_reg.dp_wr && wr_idx == `IDX_DIR_SET |=> st_reg.dir == $past(st_reg.dir | wd))
        else $error("direction set strobe wrong");
    chk_dir_clr_bits: assert property (@(posedge sys_clk) disable iff (reset)
        ce && st_reg.dp_wr && wr_idx == `IDX_DIR_CLR |=> st_reg.dir == $past(st_reg.dir & ~wd))
        else $error("direction clear strobe wrong");
    chk_dir_tgl_bits: assert property (@(posedge sys_clk) disable iff (reset)
        ce && st_reg.dp_wr && wr_idx == `IDX_DIR_TGL |=> st_reg.dir == $past(st_reg.dir ^ wd))
        else $error("direction toggle strobe wrong");
    chk_out_set_bits: assert property (@(posedge sys_clk) disable iff (reset)
        ce && st_reg.dp_wr && wr_idx == `IDX_OUT_SET |=> st_reg.out == $past(st_reg.out | wd))
        else $error("level high strobe wrong");
    chk_out_clr_bits: assert property (@(posedge sys_clk) disable iff (reset)
        ce && st_reg.dp_wr && wr_idx == `IDX_OUT_CLR |=> st_reg.out == $past(st_reg.out & ~wd))
        else $error("level low strobe wrong");
    chk_in_write_toggle: assert property (@(posedge sys_clk) disable iff (reset)
        ce && st_reg.dp_wr && wr_idx == `IDX_IN |=> st_reg.out == $past(st_reg.out ^ wd))
        else $error("input write did not toggle output level");
    chk_oe_follows_dir: assert property (@(posedge sys_clk) disable iff (reset)
        ce |=> pad_oe == st_reg.dir)
        else $error("output enable does not follow direction");
    chk_flag_set_wins: assert property (@(posedge sys_clk) disable iff (reset)
        ce && hit != 8'h00 |=> (st_reg.flags & $past(hit)) == $past(hit) && irq == |(st_reg.flags & $past(irq_en)))
        else $error("event flag lost or request wrong");
    chk_dead_time: assert property (@(posedge sys_clk) disable iff (reset)
        ce && hit[0] && !ASYNC_PINS[0] |=> !hit[0] [*2])
        else $error("event recognised inside dead time");
    chk_off_freezes: assert property (@(posedge sys_clk) disable iff (reset)
        ce && off_mask[1] && $past(off_mask[1]) |=> $stable(st_reg.lvl[1]) && $stable(st_reg.s1[1]))
        else $error("synchroniser ran with receiver off");

endmodule : gpio_pin_group
`default_nettype wire

//--- rtl/gpio_pkg.sv
// Types shared by the pin group controller.
package gpio_pkg;
    typedef struct packed {
        logic [7:0]  dir;
        logic [7:0]  out;
        logic [63:0] setup;
        logic [7:0]  s1;
        logic [7:0]  s2;
        logic [7:0]  s3;
        logic [7:0]  lvl;
        logic [7:0]  prev;
        logic [7:0]  flags;
        logic [15:0] dead;
        logic [7:0]  pad_out;
        logic [7:0]  pad_oe;
        logic [7:0]  pull;
        logic [7:0]  pin_val;
        logic        dp_wr;
        logic        dp_rd;
        logic [5:0]  dp_idx;
        logic [31:0] rdata;
        logic        ready;
        logic        resp;
        logic        irq;
        logic        wake;
    } port_state_type;
endpackage : gpio_pkg

//--- test/gpio_pad_model.sv
// Pad model standing between the pin group and the outside world.
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_model (
    input  wire logic       sys_clk,  // Clock for the floating pattern
    input  wire logic [7:0] pad_out,  // Level driven by the block
    input  wire logic [7:0] pad_oe,   // Block drives the pad when high
    input  wire logic [7:0] pad_pull, // Weak pull-up enables
    input  wire logic [7:0] ext_en,   // Far side drives the pad when high
    input  wire logic [7:0] ext_lvl,  // Level driven by the far side
    output var  logic [7:0] pad_in    // Resolved pad level
);
    logic [7:0] float_pat = 8'h55;
    // A floating pad changes every cycle so that no stale level passes for a driven one.
    always @(posedge sys_clk) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_en[i])
                pad_in[i] = ext_lvl[i];
            else if (pad_pull[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = float_pat[i];
        end
    end
endmodule : gpio_pad_model
`default_nettype wire

//--- test/test_gpio_pin_group_controller.sv
// Self-checking testbench for the pin group controller.
`timescale 1ns/1ns
`default_nettype none
module test_gpio_pin_group_controller;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        ce      = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [7:0]  ext_en  = 8'h00;
    logic [7:0]  ext_lvl = 8'h00;
    logic        hreadyout, hresp, irq, wake;
    logic [31:0] hrdata, rd;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_pull, pin_value;
    int          n_fail = 0;
    int          samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    gpio_pin_group dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull(pad_pull), .pin_value(pin_value),
        .irq(irq), .wake(wake));
    gpio_pad_model pads (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pull(pad_pull), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pad_in));
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Ready is sampled at the rising edge, exactly where the slave completes a phase.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
            chk("bus ready", 1, 0);
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, idx, 2'b00};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
        chk("bus response", 0, hresp);
    endtask : bus
    task automatic settle();
        repeat (8) @(posedge sys_clk);
    endtask : settle
    // ==========================================
    // Scenarios
    task automatic test_reset();
        chk("pad_oe", 0, pad_oe);
        chk("pad_pull", 0, pad_pull);
        bus(0, 6'h00, 8'h00);
        chk("drive_enable", 0, rd);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_direction();
        bus(1, 6'h00, 8'h0F);
        bus(1, 6'h01, 8'h30);
        bus(1, 6'h02, 8'h03);
        bus(1, 6'h03, 8'h81);
        bus(0, 6'h01, 8'h00);
        chk("drive_enable", 32'hBD, rd);
        chk("pad_oe", 32'hBD, pad_oe);
        $display("test_direction done");
    endtask : test_direction
    task automatic test_level();
        bus(1, 6'h04, 8'h55);
        bus(1, 6'h05, 8'h0A);
        bus(1, 6'h06, 8'h41);
        bus(1, 6'h07, 8'h03);
        bus(1, 6'h08, 8'h80);
        bus(1, 6'h22, 8'h01);
        bus(0, 6'h04, 8'h00);
        chk("output level", 32'h9C, rd);
        chk("pad_out", 32'h9C, pad_out);
        bus(0, 6'h0A, 8'h00);
        chk("unmapped read", 0, rd);
        $display("test_level done");
    endtask : test_level
    task automatic test_input();
        bus(1, 6'h20, 8'h10);
        ext_en  <= 8'h03;
        ext_lvl <= 8'h02;
        settle();
        bus(0, 6'h08, 8'h00);
        chk("input value", 32'h12, rd & 32'h13);
        bus(1, 6'h11, 8'h04);
        ext_lvl <= 8'h00;
        settle();
        bus(0, 6'h08, 8'h00);
        chk("frozen input", 32'h02, rd & 32'h02);
        bus(1, 6'h11, 8'h80);
        bus(1, 6'h14, 8'h88);
        settle();
        bus(0, 6'h08, 8'h00);
        chk("flipped input", 32'h12, rd & 32'h12);
        chk("flipped pad_out", 32'h8E, pad_out);
        chk("pad_pull", 32'h10, pad_pull);
        $display("test_input done");
    endtask : test_input
    task automatic test_irq();
        int n;
        bus(1, 6'h10, 8'h02);
        settle();
        bus(1, 6'h09, 8'hFF);
        settle();
        chk("idle irq", 0, irq);
        ext_lvl <= 8'h01;
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk("irq raised", 1, irq);
        bus(0, 6'h09, 8'h00);
        chk("event flag", 32'h01, rd & 32'h01);
        bus(1, 6'h23, 8'h01);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("irq cleared", 0, irq);
        $display("test_irq done");
    endtask : test_irq
    // ==========================================
    // Verdict and sequence
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        test_reset();
        test_direction();
        test_level();
        test_input();
        test_irq();
        print_verdict();
    end
endmodule : test_gpio_pin_group_controller
`default_nettype wire
